// file: verilog/cbu_pkg.sv
package cbu_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int CBU_ADDR_W = 8;
    localparam int CBU_DATA_W = 32;
    localparam int CBU_STRB_W = 4;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CBU_OFF_CTRL = 8'h00;
    localparam logic [7:0] CBU_OFF_INSTR = 8'h04;
    localparam logic [7:0] CBU_OFF_CHAIN = 8'h08;
    localparam logic [7:0] CBU_OFF_GREG = 8'h0c;
    localparam logic [7:0] CBU_OFF_FMASK = 8'h10;
    localparam logic [7:0] CBU_OFF_PSW = 8'h14;
    localparam logic [7:0] CBU_OFF_STATUS = 8'h18;
    localparam logic [7:0] CBU_OFF_INDEX = 8'h1c;

    // ----------------------------------------------------------------
    // Field indices; word bit 0 is the MSB, so position p is index 31-p
    // ----------------------------------------------------------------
    localparam int CBU_PSW_B0 = 31;
    localparam int CBU_CC_HI = 30;
    localparam int CBU_CC_LO = 27;
    localparam int CBU_PSW_B5 = 26;
    localparam int CBU_MID_HI = 25;
    localparam int CBU_MID_LO = 19;
    localparam int CBU_ADR_HI = 18;
    localparam int CBU_ADR_LO = 1;
    localparam int CBU_PSW_B31 = 0;
    localparam int CBU_D_HI = 25;
    localparam int CBU_D_LO = 23;
    localparam int CBU_X_HI = 22;
    localparam int CBU_X_LO = 21;
    localparam int CBU_IND = 20;
    localparam int CBU_FN_TOP = 15;
    localparam logic [17:0] CBU_WORD_STEP = 18'h00002;
    localparam logic [31:0] CBU_INCR_B31 = 32'h00000001;

    // Control and status bit positions.
    localparam int CBU_CTRL_START = 0;
    localparam int CBU_CTRL_OP_LO = 1;
    localparam int CBU_STAT_BUSY = 0;
    localparam int CBU_STAT_DONE = 1;
    localparam int CBU_STAT_TAKEN = 2;

    // Reset values.
    localparam logic [31:0] CBU_WORD_RST = 32'h00000000;
    localparam logic [1:0] CBU_OP_RST = 2'h0;

    // Operation selects.
    localparam logic [1:0] CBU_OP_COND_FALSE = 2'h0;
    localparam logic [1:0] CBU_OP_COND_TRUE = 2'h1;
    localparam logic [1:0] CBU_OP_FUNC_TRUE = 2'h2;
    localparam logic [1:0] CBU_OP_INCR_BYTE = 2'h3;

    localparam logic [1:0] CBU_RESP_OKAY = 2'h0;
    localparam logic [1:0] CBU_RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {CBU_IDLE, CBU_EXEC} cbu_state_e;

endpackage

// file: verilog/cbu_axil.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_axil (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [cbu_pkg::CBU_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [cbu_pkg::CBU_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [cbu_pkg::CBU_STRB_W-1:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [cbu_pkg::CBU_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [cbu_pkg::CBU_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic wr_en_o,
    output logic [cbu_pkg::CBU_ADDR_W-1:0] wr_addr_o,
    output logic [cbu_pkg::CBU_DATA_W-1:0] wr_data_o,
    output logic [cbu_pkg::CBU_STRB_W-1:0] wr_strb_o,
    input wire logic wr_ok_i,
    output logic rd_en_o,
    output logic [cbu_pkg::CBU_ADDR_W-1:0] rd_addr_o,
    input wire logic [cbu_pkg::CBU_DATA_W-1:0] rd_data_i,
    input wire logic rd_ok_i
);
    import cbu_pkg::*;

    logic aw_held_r;
    logic w_held_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    logic [CBU_ADDR_W-1:0] awaddr_r;
    logic [CBU_DATA_W-1:0] wdata_r;
    logic [CBU_STRB_W-1:0] wstrb_r;
    logic [CBU_DATA_W-1:0] rdata_r;
    wire logic aw_take;
    wire logic w_take;
    wire logic ar_take;
    wire logic wr_commit;

    // Address and data are caught separately so either may come first.
    assign s_axi_awready_o = !aw_held_r && !bvalid_r;
    assign s_axi_wready_o = !w_held_r && !bvalid_r;
    assign s_axi_arready_o = !rvalid_r;
    assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
    assign wr_commit = aw_held_r && w_held_r && !bvalid_r;

    assign wr_en_o = wr_commit;
    assign wr_addr_o = awaddr_r;
    assign wr_data_o = wdata_r;
    assign wr_strb_o = wstrb_r;
    assign rd_en_o = ar_take;
    assign rd_addr_o = s_axi_araddr_i;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rresp_o = rresp_r;
    assign s_axi_rdata_o = rdata_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
        end else if (wr_commit) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
        end else if (wr_commit) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= CBU_RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok_i ? CBU_RESP_OKAY : CBU_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rresp_r <= CBU_RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_ok_i ? CBU_RESP_OKAY : CBU_RESP_SLVERR;
            rdata_r <= rd_ok_i ? rd_data_i : '0;
        end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: verilog/cbu_top.sv
// Operation
// - direct taken branch loads address bits 13-30
// - false branch select codes 1 to 7
// - false condition not met: no branch
// - indirect taken false branch copies bits 1-4
// - direct true/false branches keep condition code
// - indirect true/false branches load chain bits 1-4
// - indirect true branch copies bits 1-4
// - function bit chosen by current condition code
// - code n selects mask bit 16 plus n
// - function zero: advance one word at bit 29
// - indirect taken function branch loads bits 1-4 and 6-30
// - increment at bit 31, branch if nonzero
// - zero sum: next sequential instruction
// - index, indirect and address instruction fields
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cbu_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [cbu_pkg::CBU_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [cbu_pkg::CBU_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [cbu_pkg::CBU_STRB_W-1:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [cbu_pkg::CBU_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [cbu_pkg::CBU_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [cbu_pkg::CBU_DATA_W-1:0] program_status_word_o,
    output logic branch_taken_o,
    output logic exec_done_o
);
    import cbu_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------

    // Only whole aligned words at the defined offsets are mapped.
    function automatic logic addr_hit(input logic [CBU_ADDR_W-1:0] a);
        addr_hit = (a == CBU_OFF_CTRL) || (a == CBU_OFF_INSTR) ||
                   (a == CBU_OFF_CHAIN) || (a == CBU_OFF_GREG) ||
                   (a == CBU_OFF_FMASK) || (a == CBU_OFF_PSW) ||
                   (a == CBU_OFF_STATUS) || (a == CBU_OFF_INDEX);
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        merge_bytes = res;
    endfunction

    // Condition codes arrive as {cc1, cc2, cc3, cc4}.
    function automatic logic cond_false_hit(input logic [2:0] d, input logic [3:0] c);
        case (d)
            3'h1: cond_false_hit = !c[3];
            3'h2: cond_false_hit = !c[2];
            3'h3: cond_false_hit = !c[1];
            3'h4: cond_false_hit = !c[0];
            3'h5: cond_false_hit = !c[2] && !c[0];
            3'h6: cond_false_hit = !c[1] && !c[0];
            3'h7: cond_false_hit = (c == 4'h0);
            default: cond_false_hit = 1'b0;
        endcase
    endfunction

    // Select code 4 has no defined test, so it never branches.
    function automatic logic cond_true_hit(input logic [2:0] d, input logic [3:0] c);
        case (d)
            3'h1: cond_true_hit = c[3];
            3'h2: cond_true_hit = c[2];
            3'h3: cond_true_hit = c[1];
            3'h5: cond_true_hit = c[0];
            3'h6: cond_true_hit = c[2] || c[0];
            3'h7: cond_true_hit = c[1] || c[0];
            default: cond_true_hit = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    wire logic wr_en;
    wire logic [CBU_ADDR_W-1:0] wr_addr;
    wire logic [CBU_DATA_W-1:0] wr_data;
    wire logic [CBU_STRB_W-1:0] wr_strb;
    wire logic wr_ok;
    wire logic rd_en;
    wire logic [CBU_ADDR_W-1:0] rd_addr;
    logic [CBU_DATA_W-1:0] rd_data;
    wire logic rd_ok;

    cbu_axil u_axil (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o),
        .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o),
        .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o),
        .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o),
        .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_ok_i(wr_ok),
        .rd_en_o(rd_en),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    assign wr_ok = addr_hit(wr_addr);
    assign rd_ok = rd_en && addr_hit(rd_addr);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    cbu_state_e state_r;
    cbu_state_e state_nxt;
    logic [1:0] op_r;
    logic [31:0] instr_r;
    logic [31:0] chain_r;
    logic [31:0] greg_r;
    logic [31:0] fmask_r;
    logic [31:0] psw_r;
    logic [31:0] index_r;
    logic taken_r;
    logic done_r;
    logic done_pulse_r;

    wire logic idle;
    wire logic exec;
    wire logic wr_ctrl;
    wire logic start_req;

    assign idle = (state_r == CBU_IDLE);
    assign exec = (state_r == CBU_EXEC);
    assign wr_ctrl = wr_en && (wr_addr == CBU_OFF_CTRL) && wr_strb[0];
    // A start while a branch is still executing is dropped.
    assign start_req = wr_ctrl && wr_data[CBU_CTRL_START] && idle;

    // Operand registers are frozen while the branch executes.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            op_r <= CBU_OP_RST;
        end else if (wr_ctrl && idle) begin
            op_r <= wr_data[CBU_CTRL_OP_LO +: 2];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            instr_r <= CBU_WORD_RST;
            chain_r <= CBU_WORD_RST;
            fmask_r <= CBU_WORD_RST;
            index_r <= CBU_WORD_RST;
        end else if (wr_en && idle) begin
            if (wr_addr == CBU_OFF_INSTR) instr_r <= merge_bytes(instr_r, wr_data, wr_strb);
            if (wr_addr == CBU_OFF_CHAIN) chain_r <= merge_bytes(chain_r, wr_data, wr_strb);
            if (wr_addr == CBU_OFF_FMASK) fmask_r <= merge_bytes(fmask_r, wr_data, wr_strb);
            if (wr_addr == CBU_OFF_INDEX) index_r <= merge_bytes(index_r, wr_data, wr_strb);
        end
    end

    // ----------------------------------------------------------------
    // Instruction fields
    // ----------------------------------------------------------------
    wire logic [2:0] d_sel;
    wire logic [1:0] x_sel;
    wire logic ind;
    wire logic [17:0] base_addr;
    wire logic [17:0] ea;
    wire logic [3:0] cc;
    wire logic [17:0] seq_addr;

    assign d_sel = instr_r[CBU_D_HI:CBU_D_LO];
    assign x_sel = instr_r[CBU_X_HI:CBU_X_LO];
    assign ind = instr_r[CBU_IND];
    assign base_addr = instr_r[CBU_ADR_HI:CBU_ADR_LO];
    // The chain word already holds the fully resolved address, so indexing
    // applies only to direct branches; the increment branch takes none.
    assign ea = ind ? chain_r[CBU_ADR_HI:CBU_ADR_LO] :
                ((x_sel != 2'h0) && (op_r != CBU_OP_INCR_BYTE)) ?
                base_addr + index_r[CBU_ADR_HI:CBU_ADR_LO] : base_addr;
    assign cc = psw_r[CBU_CC_HI:CBU_CC_LO];
    // Word step is a carry into bit 29 of the address field.
    assign seq_addr = psw_r[CBU_ADR_HI:CBU_ADR_LO] + CBU_WORD_STEP;

    // ----------------------------------------------------------------
    // Branch decision
    // ----------------------------------------------------------------
    wire logic false_hit;
    wire logic true_hit;
    wire logic [3:0] fn_sel;
    wire logic fn_bit;
    wire logic [31:0] greg_inc;
    wire logic incr_hit;
    wire logic take;

    assign false_hit = cond_false_hit(d_sel, cc);
    assign true_hit = cond_true_hit(d_sel, cc);
    // Code n picks mask position 16+n, which is index 15-n.
    assign fn_sel = 4'(CBU_FN_TOP) - cc;
    assign fn_bit = fmask_r[fn_sel];
    assign greg_inc = greg_r + CBU_INCR_B31;
    assign incr_hit = (greg_inc != CBU_WORD_RST);

    assign take = (op_r == CBU_OP_COND_FALSE) ? false_hit :
                  (op_r == CBU_OP_COND_TRUE) ? true_hit :
                  (op_r == CBU_OP_FUNC_TRUE) ? fn_bit : incr_hit;

    // ----------------------------------------------------------------
    // Next program status word
    // ----------------------------------------------------------------
    wire logic cc_from_chain;
    wire logic mid_from_chain;
    wire logic [3:0] cc_nxt;
    wire logic [6:0] mid_nxt;
    wire logic [17:0] addr_nxt;
    wire logic [31:0] psw_nxt;

    // The increment branch is left out here so its codes never move.
    assign cc_from_chain = ind && (op_r != CBU_OP_INCR_BYTE);
    assign mid_from_chain = ind && take && (op_r == CBU_OP_FUNC_TRUE);
    assign cc_nxt = cc_from_chain ? chain_r[CBU_CC_HI:CBU_CC_LO] : cc;
    assign mid_nxt = mid_from_chain ? chain_r[CBU_MID_HI:CBU_MID_LO] :
                     psw_r[CBU_MID_HI:CBU_MID_LO];
    assign addr_nxt = take ? ea : seq_addr;
    // Bits 0, 5 and 31 pass through untouched in every case.
    assign psw_nxt = {psw_r[CBU_PSW_B0], cc_nxt, psw_r[CBU_PSW_B5], mid_nxt,
                      addr_nxt, psw_r[CBU_PSW_B31]};

    // ----------------------------------------------------------------
    // Execution sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CBU_IDLE: begin
                if (start_req) begin
                    state_nxt = CBU_EXEC;
                end
            end
            CBU_EXEC: begin
                state_nxt = CBU_IDLE;
            end
            default: begin
                state_nxt = CBU_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= CBU_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The result of a branch wins over a bus write on the same edge, so
    // software cannot tear the program status word mid-execution.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            psw_r <= CBU_WORD_RST;
        end else if (exec) begin
            psw_r <= psw_nxt;
        end else if (wr_en && (wr_addr == CBU_OFF_PSW)) begin
            psw_r <= merge_bytes(psw_r, wr_data, wr_strb);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            greg_r <= CBU_WORD_RST;
        end else if (exec && (op_r == CBU_OP_INCR_BYTE)) begin
            greg_r <= greg_inc;
        end else if (wr_en && idle && (wr_addr == CBU_OFF_GREG)) begin
            greg_r <= merge_bytes(greg_r, wr_data, wr_strb);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            taken_r <= 1'b0;
            done_r <= 1'b0;
            done_pulse_r <= 1'b0;
        end else begin
            done_pulse_r <= exec;
            if (exec) begin
                taken_r <= take;
                done_r <= 1'b1;
            end else if (start_req) begin
                done_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Readback
    // ----------------------------------------------------------------
    wire logic [31:0] ctrl_rd;
    wire logic [31:0] status_rd;

    assign ctrl_rd = {29'h0, op_r, 1'b0};
    assign status_rd = {29'h0, taken_r, done_r, !idle};

    assign rd_data = (rd_addr == CBU_OFF_CTRL) ? ctrl_rd :
                     (rd_addr == CBU_OFF_INSTR) ? instr_r :
                     (rd_addr == CBU_OFF_CHAIN) ? chain_r :
                     (rd_addr == CBU_OFF_GREG) ? greg_r :
                     (rd_addr == CBU_OFF_FMASK) ? fmask_r :
                     (rd_addr == CBU_OFF_PSW) ? psw_r :
                     (rd_addr == CBU_OFF_STATUS) ? status_rd :
                     (rd_addr == CBU_OFF_INDEX) ? index_r : CBU_WORD_RST;

    assign program_status_word_o = psw_r;
    assign branch_taken_o = taken_r;
    assign exec_done_o = done_pulse_r;

endmodule
`default_nettype wire

// file: tb/cbu_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_properties (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [cbu_pkg::CBU_DATA_W-1:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [cbu_pkg::CBU_DATA_W-1:0] program_status_word_o,
    input wire logic branch_taken_o,
    input wire logic exec_done_o
);
    import cbu_pkg::*;
    // ----------------------------------------------------------------
    // Bus answers and execution results
    // ----------------------------------------------------------------
    // The word before each execution, kept here so no slice goes through $past.
    logic [31:0] psw_prev_r;
    always_ff @(posedge mclk_i) psw_prev_r <= program_status_word_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence both_taken_s;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence no_branch_s;
        exec_done_o && !branch_taken_o;
    endsequence
    write_resp_a:
    assert property (both_taken_s |=> ##1 s_axi_bvalid_o) else $error("no write response");
    bresp_hold_a:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
        $stable(s_axi_bresp_o)) else $error("write response dropped");
    read_resp_a:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("no read response");
    rdata_hold_a:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
        $stable(s_axi_rdata_o)) else $error("read data dropped");
    done_pulse_a:
    assert property (exec_done_o |=> !exec_done_o) else $error("done longer than a cycle");
    taken_moves_a:
    assert property (!$past(rst_i) && $changed(branch_taken_o) |-> exec_done_o)
        else $error("stray taken");
    fixed_bits_a:
    assert property (exec_done_o |-> {program_status_word_o[31], program_status_word_o[26],
        program_status_word_o[0]} == {psw_prev_r[31], psw_prev_r[26], psw_prev_r[0]})
        else $error("kept bits changed");
    untaken_step_a:
    assert property (no_branch_s |-> program_status_word_o[18:1] ==
        psw_prev_r[18:1] + CBU_WORD_STEP) else $error("no one word step");
endmodule
bind cbu_top cbu_properties prop_u (.*);
`default_nettype wire

// file: tb/conditional_branch_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_unit_test;
    import cbu_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic [31:0] instr, chain, fmask, greg, psw, exp_psw;
        logic taken;
    } cbu_row_s;
    logic mclk_i = 1'b0, rst_i = 1'b1;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o, program_status_word_o;
    logic branch_taken_o, exec_done_o;
    int num_errors = 0;
    int compares = 0;
    // ----------------------------------------------------------------
    // Cases: op, instruction, chain word, mask, register, word in, word out, taken
    // ----------------------------------------------------------------
    cbu_row_s rows [12] = '{
        '{2'h0, 32'h0100214c, 32'h0, 32'h0, 32'h0, 32'h10002094, 32'h1000214c, 1'h1},
        '{2'h0, 32'h02803000, 32'h0, 32'h0, 32'h0, 32'h28001000, 32'h28001004, 1'h0},
        '{2'h0, 32'h03103000, 32'h50001234, 32'h0, 32'h0, 32'h84001000, 32'hd4001234, 1'h1},
        '{2'h0, 32'h03803000, 32'h0, 32'h0, 32'h0, 32'h08000040, 32'h08000044, 1'h0},
        '{2'h1, 32'h00a01414, 32'h0, 32'h0, 32'h0, 32'h50001000, 32'h50001514, 1'h1},
        '{2'h1, 32'h03803000, 32'h0, 32'h0, 32'h0, 32'h20000200, 32'h20000204, 1'h0},
        '{2'h1, 32'h02903000, 32'h78000800, 32'h0, 32'h0, 32'h00000400, 32'h78000404, 1'h0},
        '{2'h1, 32'h03103000, 32'h08000abc, 32'h0, 32'h0, 32'h24000010, 32'h0c000abc, 1'h1},
        '{2'h2, 32'h00002000, 32'h0, 32'h2, 32'h0, 32'h70001000, 32'h70002000, 1'h1},
        '{2'h2, 32'h00002000, 32'h0, 32'hfffffffd, 32'h0, 32'h70001000, 32'h70001004, 1'h0},
        '{2'h3, 32'h00001ba8, 32'h0, 32'h0, 32'hffffffff, 32'h2001b204, 32'h2001b208, 1'h0},
        '{2'h3, 32'h00100000, 32'h7800abcc, 32'h0, 32'hff, 32'h58001000, 32'h5800abcc, 1'h1}
    };
    cbu_top dut_u (.*);
    initial forever #12.5 mclk_i = ~mclk_i;
    task automatic stop_test();
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        $display("Error %0t: no answer", $time);
        stop_test();
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) break;
        end
        if (n == 40) hang();
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) break;
        end
        if (n == 40) hang();
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask
    task automatic run_row(input cbu_row_s w);
        logic [31:0] g;
        logic [1:0] r;
        int n;
        axi_write(CBU_OFF_FMASK, w.fmask, r);
        axi_write(CBU_OFF_GREG, w.greg, r);
        axi_write(CBU_OFF_CHAIN, w.chain, r);
        axi_write(CBU_OFF_PSW, w.psw, r);
        axi_write(CBU_OFF_INSTR, w.instr, r);
        axi_write(CBU_OFF_CTRL, {29'h0, w.op, 1'b1}, r);
        for (n = 0; n < 20 && exec_done_o !== 1'b1; n++) @(posedge mclk_i);
        if (n == 20) hang();
        check_word(program_status_word_o, w.exp_psw);
        check_flag(branch_taken_o, w.taken);
        axi_read(CBU_OFF_GREG, g, r);
        check_word(g, (w.op == CBU_OP_INCR_BYTE) ? w.greg + CBU_INCR_B31 : w.greg);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        check_word(program_status_word_o, 32'h0);
        axi_write(CBU_OFF_INDEX, 32'h00000100, r);
        foreach (rows[i]) run_row(rows[i]);
        // Last case branched, so the status word shows done and taken, not busy.
        axi_read(CBU_OFF_STATUS, d, r);
        check_word(d, 32'h00000006);
        axi_read(8'h20, d, r);
        check_word({d[31:2], r}, {30'h0, CBU_RESP_SLVERR});
        axi_write(8'h24, 32'h1, r);
        check_word({30'h0, r}, {30'h0, CBU_RESP_SLVERR});
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check_word(program_status_word_o, 32'h0);
        check_flag(branch_taken_o, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
